// >>> common/sbp_pkg.sv
// Shared constants for the two-bank SDRAM burst and precharge core
//
// Functional notes
// - Precharge with bit ten low closes the bank chosen; high closes both, bank bit ignored.
// - Bank select bit zero targets bank 0, one targets bank 1.
// - Active command takes an eleven-bit row; bit ten is a row bit there.
// - Read/write: column bits 0-7 used, 8-9 ignored, bit ten auto-precharge, bit eleven bank.
// - Read starts at the given column, data after CAS latency, then successive columns.
// - Output drivers on one cycle before data, released after the final fixed-length word.
// - Full-page reads keep driving until a burst stop command arrives.
// - Read byte masks act per byte, two clocks after assertion, any CAS latency.
// - Write takes its first word in the command cycle, later words at generated columns.
// - Write burst ends after burst length clocks; full page needs burst stop.
// - Write byte masks block storing each byte in the same cycle.
// - Read auto-precharge starts one (CL2) or two (CL3) clocks before the final output.
// - Write auto-precharge starts one clock after the last input word.
// - Full-page burst length disables auto-precharge on reads and writes.
// - A new read replaces a running read's data once CAS latency elapses.
// - A new write replaces a running write's data from its own command cycle.
// - Bank returns to idle a precharge period after precharge starts.
// - Full page spans 256 columns, wrapping within the row from the start.
// - Burst column order is sequential or interleaved from the start column.
// - Single-write mode stores one word per write; reads still burst.
package sbp_pkg;

  // ****************************************************************
  // Command encoding {chip select, row strobe, column strobe, write}
  // ****************************************************************
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;

  // ****************************************************************
  // Address fields
  // ****************************************************************
  localparam int ADDR_BANK_BIT = 11;
  localparam int ADDR_TEN_BIT = 10;

  // ****************************************************************
  // Register map and mode field layout
  // ****************************************************************
  localparam logic [11:0] REG_MODE = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int MODE_CL_LSB = 0;
  localparam int MODE_BL_LSB = 2;
  localparam int MODE_TYPE_BIT = 5;
  localparam int MODE_SINGLE_BIT = 6;
  localparam logic [1:0] MODE_CL_RESET = 2'h2;
  localparam logic [2:0] MODE_BL_RESET = 3'h3;
  localparam logic [1:0] CL_THREE = 2'h3;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRECHARGE_NS = 20;
  localparam int PRECHARGE_CYC_INT = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PRECHARGE_CYC = 4'(PRECHARGE_CYC_INT < 1 ? 1 : PRECHARGE_CYC_INT);

  // Bank states, one-hot
  typedef enum logic [2:0] {
    SBP_IDLE = 3'b001,
    SBP_ACTIVE = 3'b010,
    SBP_PRECH = 3'b100
  } sbp_bank_e;

endpackage : sbp_pkg

// >>> verilog/sbp_col_gen.sv
// Burst column sequencer: start column plus beat number to column address
`timescale 1ns/1ps
module sbp_col_gen import sbp_pkg::*; (
  input wire logic [7:0] start_col,
  input wire logic [8:0] beat,
  input wire logic [2:0] len_code,
  input wire logic interleave,
  output logic [7:0] col
);

  logic [7:0] wrap_mask;
  logic [7:0] low_bits;

  // Wrap window from the burst length; reserved codes act as length one
  always_comb begin
    case (len_code)
      3'h1: wrap_mask = 8'h01;
      3'h2: wrap_mask = 8'h03;
      3'h3: wrap_mask = 8'h07;
      BL_FULL_PAGE: wrap_mask = 8'hff;
      default: wrap_mask = 8'h00;
    endcase
  end

  // Interleave exists only for fixed lengths; full page is always sequential
  always_comb begin
    if (interleave && len_code != BL_FULL_PAGE) begin
      low_bits = start_col ^ beat[7:0];
    end else begin
      low_bits = 8'(start_col + beat[7:0]);
    end
    col = (start_col & ~wrap_mask) | (low_bits & wrap_mask);
  end

endmodule : sbp_col_gen

// >>> verilog/sbp_bank.sv
// One bank's row state: idle, active with an open row, or precharging
`timescale 1ns/1ps
module sbp_bank import sbp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic activate,
  input wire logic precharge,
  input wire logic [10:0] row_in,
  output logic bank_active,
  output logic [10:0] open_row,
  output logic [2:0] state_code
);

  typedef struct packed {
    sbp_bank_e state;
    logic [10:0] row;
    logic [3:0] wait_cnt;
  } sbp_bank_s;

  sbp_bank_s st;
  sbp_bank_s next_st;

  // Idle takes activate and ignores a precharge in the same cycle; only an active bank acts on precharge
  always_comb begin
    next_st = st;
    case (st.state)
      SBP_IDLE: begin
        if (activate) begin
          next_st.state = SBP_ACTIVE;
          next_st.row = row_in;
        end
      end
      SBP_ACTIVE: begin
        if (precharge) begin
          next_st.state = SBP_PRECH;
          next_st.wait_cnt = 4'(PRECHARGE_CYC - 4'h1);
        end
      end
      SBP_PRECH: begin
        if (st.wait_cnt == 4'h0 && activate) begin
          // The precharge period is over at this edge, so an activation here must not be lost
          next_st.state = SBP_ACTIVE;
          next_st.row = row_in;
        end else if (st.wait_cnt == 4'h0) begin
          next_st.state = SBP_IDLE;
        end else begin
          next_st.wait_cnt = 4'(st.wait_cnt - 4'h1);
        end
      end
      default: next_st.state = SBP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{state: SBP_IDLE, row: 11'h000, wait_cnt: 4'h0};
    end else begin
      st <= next_st;
    end
  end

  assign bank_active = (st.state == SBP_ACTIVE);
  assign open_row = st.row;
  assign state_code = st.state;

  a_idle_after_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (st.state == SBP_PRECH && st.wait_cnt == 4'h0) |=> st.state == ($past(activate) ? SBP_ACTIVE : SBP_IDLE))
    else $error("bank did not return to idle after precharge period");

endmodule : sbp_bank

// >>> verilog/sbp_core.sv
// SDRAM command, burst, masking and auto-precharge core with APB mode access
`timescale 1ns/1ps
module sbp_core import sbp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command pins, sampled on the rising edge
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic [11:0] addr,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  // Data pins split into input, output and per-byte enable
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0] cl_field;
    logic [2:0] bl_code;
    logic interleave;
    logic single_wr;
    logic busy;
    logic wr;
    logic ap;
    logic bank;
    logic [10:0] row;
    logic [7:0] start_col;
    logic [8:0] beat;
    logic v0;
    logic [15:0] d0;
    logic v1;
    logic [15:0] d1;
    logic [1:0] mq1;
    logic [1:0] mq2;
    logic [31:0] prdata;
  } sbp_core_s;

  sbp_core_s st;
  sbp_core_s next_st;

  localparam int MEM_WORDS = 1 << 20;
  logic [15:0] mem_array [0:MEM_WORDS-1];

  logic [3:0] cmd;
  logic is_act;
  logic is_read;
  logic is_write;
  logic is_pre;
  logic is_stop;
  logic full_page;
  logic cl3;
  logic [8:0] burst_len;
  logic [7:0] burst_col;
  logic cur_v;
  logic [19:0] rd_addr;
  logic mem_we;
  logic [19:0] mem_addr;
  logic [1:0] mem_be;
  logic ap_fire;
  logic [1:0] act_bank;
  logic [1:0] pre_bank;
  logic [1:0] bank_active;
  logic [10:0] open_row [0:1];
  logic [2:0] bank_state [0:1];
  logic read_drive;
  logic apb_setup;
  logic apb_access;
  logic addr_ok;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Pins come from logic on this same clock, so no synchroniser is used
  assign cmd = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
  assign is_act = (cmd == CMD_ACTIVE);
  assign is_read = (cmd == CMD_READ);
  assign is_write = (cmd == CMD_WRITE);
  assign is_pre = (cmd == CMD_PRECHARGE);
  assign is_stop = (cmd == CMD_BURST_STOP);
  assign full_page = (st.bl_code == BL_FULL_PAGE);
  assign cl3 = (st.cl_field == CL_THREE);

  // Burst length in beats; reserved codes behave as single beats
  always_comb begin
    case (st.bl_code)
      3'h1: burst_len = 9'h002;
      3'h2: burst_len = 9'h004;
      3'h3: burst_len = 9'h008;
      BL_FULL_PAGE: burst_len = 9'h100;
      default: burst_len = 9'h001;
    endcase
  end

  // ****************************************************************
  // Banks and column sequencing
  // ****************************************************************
  sbp_col_gen u_col_gen (
    .start_col(st.start_col),
    .beat(st.beat),
    .len_code(st.bl_code),
    .interleave(st.interleave),
    .col(burst_col)
  );

  // Auto-precharge and explicit precharge both close a bank through the same port
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      assign act_bank[gb] = is_act && (addr[ADDR_BANK_BIT] == 1'(gb));
      assign pre_bank[gb] = (is_pre && (addr[ADDR_TEN_BIT] || addr[ADDR_BANK_BIT] == 1'(gb)))
        || (ap_fire && st.bank == 1'(gb));
      sbp_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .activate(act_bank[gb]),
        .precharge(pre_bank[gb]),
        .row_in(addr[10:0]),
        .bank_active(bank_active[gb]),
        .open_row(open_row[gb]),
        .state_code(bank_state[gb])
      );
    end
  endgenerate

  // ****************************************************************
  // Memory access
  // ****************************************************************
  // A read beat is fetched one cycle after its column is registered
  assign cur_v = st.busy && !st.wr;
  assign rd_addr = {st.bank, st.row, burst_col};

  // The first write word lands with the command itself; later beats come from the engine
  always_comb begin
    mem_we = 1'b0;
    mem_addr = {st.bank, st.row, burst_col};
    if (is_write) begin
      mem_we = 1'b1;
      mem_addr = {addr[ADDR_BANK_BIT], open_row[addr[ADDR_BANK_BIT]], addr[7:0]};
    end else if (st.busy && st.wr && st.beat != burst_len && !is_stop && !is_read) begin
      mem_we = 1'b1;
    end
    mem_be = mem_we ? ~{upper_byte_mask, lower_byte_mask} : 2'h0;
  end

  // Memory array write port, one lane per byte
  always_ff @(posedge pclk) begin
    for (int b = 0; b < 2; b++) begin
      if (mem_be[b]) begin
        mem_array[mem_addr][b*8 +: 8] <= dq_in[b*8 +: 8];
      end
    end
  end

  // ****************************************************************
  // Burst engine, read pipeline and APB registers
  // ****************************************************************
  always_comb begin
    next_st = st;
    ap_fire = 1'b0;
    // Read data pipeline; taps chosen by CAS latency at the output
    next_st.v0 = cur_v;
    next_st.d0 = mem_array[rd_addr];
    next_st.v1 = st.v0;
    next_st.d1 = st.d0;
    // Read mask pipeline: two stages match the fixed two-clock mask delay
    next_st.mq1 = {upper_byte_mask, lower_byte_mask};
    next_st.mq2 = st.mq1;
    // Running burst advances; a fixed-length burst ends by itself at its length
    if (st.busy) begin
      if (st.wr) begin
        if (!full_page && st.beat == burst_len) begin
          next_st.busy = 1'b0;
          ap_fire = st.ap && !full_page;
        end else begin
          // Full page wraps within the row until a burst stop or a new command
          next_st.beat = full_page ? {1'b0, 8'(st.beat[7:0] + 8'h01)} : 9'(st.beat + 9'h001);
        end
      end else begin
        if (!full_page && st.beat == 9'(burst_len - 9'h001)) begin
          next_st.busy = 1'b0;
          ap_fire = st.ap;
        end else begin
          next_st.beat = full_page ? {1'b0, 8'(st.beat[7:0] + 8'h01)} : 9'(st.beat + 9'h001);
        end
      end
    end
    // A new command replaces any running burst; an interrupted burst drops its auto-precharge
    if (is_read || is_write) begin
      next_st.busy = 1'b1;
      next_st.wr = is_write;
      next_st.ap = addr[ADDR_TEN_BIT] && !full_page;
      next_st.bank = addr[ADDR_BANK_BIT];
      next_st.row = open_row[addr[ADDR_BANK_BIT]];
      next_st.start_col = addr[7:0];
      next_st.beat = is_write ? 9'h001 : 9'h000;
      if (is_write && st.single_wr) begin
        next_st.busy = 1'b0;
        ap_fire = 1'b0;
      end
      // Single write with auto-precharge still closes the bank one clock later
      if (is_write && st.single_wr && addr[ADDR_TEN_BIT] && !full_page) begin
        next_st.busy = 1'b1;
        next_st.beat = burst_len;
      end
    end else if (is_stop) begin
      next_st.busy = 1'b0;
      next_st.ap = 1'b0;
    end
    // APB: read data is registered in the setup phase and held through access
    if (apb_setup && !pwrite) begin
      case (paddr)
        REG_MODE: next_st.prdata = {25'h0, st.single_wr, st.interleave, st.bl_code, st.cl_field};
        REG_STATUS: next_st.prdata = {24'h0, st.wr, st.busy, bank_state[1], bank_state[0]};
        default: next_st.prdata = 32'h0;
      endcase
    end
    if (apb_access && pwrite && paddr == REG_MODE) begin
      next_st.cl_field = pwdata[MODE_CL_LSB +: 2];
      next_st.bl_code = pwdata[MODE_BL_LSB +: 3];
      next_st.interleave = pwdata[MODE_TYPE_BIT];
      next_st.single_wr = pwdata[MODE_SINGLE_BIT];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.cl_field <= MODE_CL_RESET;
      st.bl_code <= MODE_BL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Drivers turn on one cycle ahead of the first word and drop after the last
  assign read_drive = cl3 ? (st.v1 || st.v0) : (st.v0 || cur_v);
  assign dq_out = cl3 ? st.d1 : st.d0;
  assign dq_oe = read_drive ? ~st.mq2 : 2'h0;

  // Zero-wait APB; status is read only, so writing it reports an error
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign addr_ok = (paddr == REG_MODE) || (paddr == REG_STATUS && !pwrite);
  assign pready = apb_access;
  assign pslverr = apb_access && !addr_ok;
  assign prdata = st.prdata;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_precharge_both: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pre && addr[ADDR_TEN_BIT]) |=> bank_active == 2'b00)
    else $error("precharge-all left a bank active");

  a_bank_select: assert property (@(posedge pclk) disable iff (!presetn)
    (is_act && bank_state[addr[ADDR_BANK_BIT]] == SBP_IDLE) |=> bank_active[$past(addr[ADDR_BANK_BIT])])
    else $error("active command opened the wrong bank");

  a_row_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (is_act && !addr[ADDR_BANK_BIT] && bank_state[0] == SBP_IDLE) |=> open_row[0] == $past(addr[10:0]))
    else $error("open row differs from active address");

  a_read_start: assert property (@(posedge pclk) disable iff (!presetn)
    is_read |=> (st.busy && !st.wr && st.beat == 9'h000 && burst_col == $past(addr[7:0])))
    else $error("read burst did not start at the given column");

  a_read_drive_lead: assert property (@(posedge pclk) disable iff (!presetn)
    (is_read && cl3 && !cur_v && !st.v0) |=> !read_drive ##1 read_drive ##1 read_drive)
    else $error("CL3 read drivers not enabled one cycle before data");

  a_read_mask_delay: assert property (@(posedge pclk) disable iff (!presetn)
    upper_byte_mask |-> ##2 !dq_oe[1])
    else $error("upper read mask did not act two clocks later");

  a_write_mask_now: assert property (@(posedge pclk) disable iff (!presetn)
    (is_write && lower_byte_mask) |-> (mem_we && !mem_be[0] && mem_be[1] == !upper_byte_mask))
    else $error("write mask did not gate the byte in the command cycle");

  a_no_full_page_ap: assert property (@(posedge pclk) disable iff (!presetn)
    ap_fire |-> !full_page)
    else $error("auto-precharge fired in full-page mode");

  a_single_write: assert property (@(posedge pclk) disable iff (!presetn)
    (is_write && st.single_wr) ##1 !is_write |-> !mem_we)
    else $error("single-write mode stored a second beat");

  a_write_ap_time: assert property (@(posedge pclk) disable iff (!presetn)
    (is_write && addr[ADDR_TEN_BIT] && st.bl_code == 3'h1 && !st.single_wr) ##1 !(is_read || is_write || is_stop)
      ##1 !(is_read || is_write || is_stop) |-> ap_fire)
    else $error("write auto-precharge not one clock after the last word");

  a_read_cl2_lead: assert property (@(posedge pclk) disable iff (!presetn)
    (is_read && !cl3) |=> read_drive)
    else $error("CL2 read drivers not enabled one cycle after the command");

  a_read_oe_release: assert property (@(posedge pclk) disable iff (!presetn)
    (is_read && st.bl_code == 3'h1 && !cl3) ##1 (!(is_read || is_write)) [*3] |=> dq_oe == 2'h0)
    else $error("read drivers still on after the last word of a two-beat burst");

  a_read_mask_lower: assert property (@(posedge pclk) disable iff (!presetn)
    lower_byte_mask |-> ##2 !dq_oe[0])
    else $error("lower read mask did not act two clocks later");

  a_read_ap_lead: assert property (@(posedge pclk) disable iff (!presetn)
    (is_read && addr[ADDR_TEN_BIT] && cl3 && st.bl_code == 3'h3) ##1 (!(is_read || is_write || is_stop)) [*7]
      |=> ap_fire)
    else $error("CL3 read auto-precharge not two clocks before the last word");

  a_ap_closes_bank: assert property (@(posedge pclk) disable iff (!presetn)
    ap_fire |=> bank_state[$past(st.bank)] != SBP_ACTIVE)
    else $error("auto-precharge left its bank active");

  a_precharge_one: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pre && !addr[ADDR_TEN_BIT] && bank_active == 2'b11 && !ap_fire)
      |=> (bank_active[!$past(addr[ADDR_BANK_BIT])] && !bank_active[$past(addr[ADDR_BANK_BIT])]))
    else $error("single-bank precharge closed the wrong bank");

  a_write_first_word: assert property (@(posedge pclk) disable iff (!presetn)
    is_write |-> (mem_we && mem_addr[7:0] == addr[7:0] && mem_addr[19] == addr[ADDR_BANK_BIT]))
    else $error("write command did not store its first word at once");

  a_write_len_end: assert property (@(posedge pclk) disable iff (!presetn)
    (st.busy && st.wr && !full_page && st.beat == burst_len && !is_write) |-> !mem_we)
    else $error("write burst stored a word past its length");

  a_stop_ends_burst: assert property (@(posedge pclk) disable iff (!presetn)
    is_stop |-> !mem_we ##1 !st.busy)
    else $error("burst stop did not end the burst");

endmodule : sbp_core

// >>> tb/sbp_ctl_model.sv
// Controller model: command pins, address, byte masks and write data
`timescale 1ns/1ps
module sbp_ctl_model import sbp_pkg::*; (
  input wire logic pclk,
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_enable_n,
  output logic [11:0] addr,
  output logic upper_byte_mask,
  output logic lower_byte_mask,
  output logic [15:0] dq_drv
);
  // ****************
  // Idle pins
  // ****************
  // Deselected, no masks, data lines at an arbitrary pattern
  initial begin
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
    addr = 12'h000;
    {upper_byte_mask, lower_byte_mask} = 2'h0;
    dq_drv = 16'h5a5a;
  end

  // One command slot per call, changed just after the edge
  // Released data lines flip on every step call so a stale word can never pass for a good one
  task automatic step(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m, input logic en,
                      input logic [15:0] d);
    @(posedge pclk);
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= c;
    addr <= a;
    {upper_byte_mask, lower_byte_mask} <= m;
    dq_drv <= en ? d : ~dq_drv;
  endtask : step
endmodule : sbp_ctl_model

// >>> tb/sdram_burst_precharge_core_bench.sv
// Self-checking bench for the SDRAM burst and precharge core
`timescale 1ns/1ps
module sdram_burst_precharge_core_bench import sbp_pkg::*;;
  localparam logic [3:0] NOP_CMD = 4'hf;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000, addr;
  logic [31:0] pwdata = 32'h0, prdata, rd_val;
  logic chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, upper_byte_mask, lower_byte_mask;
  logic [15:0] dq_drv, dq_in, dq_out, xm;
  logic [1:0] dq_oe, xo, m1 = 2'h0, m2 = 2'h0;
  logic [15:0] mem [256];
  logic [15:0] ed [64];
  logic [1:0] eo [64];
  logic ev [64];
  logic il = 1'b0, sw = 1'b0;
  int n_fail = 0, n_checks = 0, cyc = 0, bl = 8, cl = 2;

  // Wire level: the device wins a byte lane while it enables it
  assign dq_in = {dq_oe[1] ? dq_out[15:8] : dq_drv[15:8], dq_oe[0] ? dq_out[7:0] : dq_drv[7:0]};

  initial begin
    forever #5 pclk = ~pclk;
  end

  sbp_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n, .addr, .upper_byte_mask,
    .lower_byte_mask, .dq_in, .dq_out, .dq_oe);
  sbp_ctl_model ctl (.pclk, .chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n, .addr,
    .upper_byte_mask, .lower_byte_mask, .dq_drv);

  // ****************
  // Checking helpers
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Per-edge output check against the scheduled read words; read masks act two edges late
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    m1 <= {upper_byte_mask, lower_byte_mask};
    m2 <= m1;
    xo = eo[cyc % 64] & ~m2;
    xm = {{8{xo[1] & ev[cyc % 64]}}, {8{xo[0] & ev[cyc % 64]}}};
    if (presetn) chk({14'h0, dq_oe, dq_out & xm}, {14'h0, xo, ed[cyc % 64] & xm});
    eo[cyc % 64] = 2'h0;
    ev[cyc % 64] = 1'b0;
    if (cyc > 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // Burst column for beat k, from the bench's own copy of the mode
  function automatic logic [7:0] col_of(input logic [7:0] s, input int k);
    logic [7:0] w;
    w = 8'(bl - 1);
    if (il) return (s & ~w) | ((s ^ 8'(k)) & w);
    return (s & ~w) | ((s + 8'(k)) & w);
  endfunction : col_of

  // ****************
  // Bus and pin tasks
  // ****************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_val = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task mode(input logic [31:0] v);
    cl = (v[1:0] == 2'h3) ? 3 : 2;
    bl = (v[4:2] == 3'h7) ? 256 : (1 << v[4:2]);
    il = v[5];
    sw = v[6];
    apb(1'b1, REG_MODE, v);
    chk({31'h0, err}, 32'h0);
  endtask : mode

  task cmd(input logic [3:0] c, input logic [11:0] a);
    ctl.step(c, a, 2'h0, 1'b0, 16'h0);
  endtask : cmd

  task nop(input int n);
    repeat (n) cmd(NOP_CMD, 12'h000);
  endtask : nop

  task st(input logic [31:0] e);
    nop(4);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd_val, e);
  endtask : st

  // Write burst of n beats; mask mk applies on beat 1 only
  task automatic wr(input logic [11:0] a, input int n, input logic [15:0] sd, input logic [1:0] mk);
    logic [15:0] d;
    logic [7:0] c;
    for (int k = 0; k < n; k++) begin
      d = sd + 16'(k * 16'h0111);
      c = col_of(a[7:0], k);
      ctl.step(k == 0 ? CMD_WRITE : NOP_CMD, a, k == 1 ? mk : 2'h0, 1'b1, d);
      if (k == 0 || !sw) begin
        mem[c] = {(mk[1] && k == 1) ? mem[c][15:8] : d[15:8],
          (mk[0] && k == 1) ? mem[c][7:0] : d[7:0]};
      end
    end
  endtask : wr

  // Read: the command is taken at the next edge; later reads overwrite pending slots
  task automatic rd(input logic [11:0] a);
    int t;
    cmd(CMD_READ, a);
    t = cyc + 1;
    eo[(t + cl - 1) % 64] = 2'h3;
    for (int j = 0; j < bl; j++) begin
      eo[(t + cl + j) % 64] = 2'h3;
      ed[(t + cl + j) % 64] = mem[col_of(a[7:0], j)];
      ev[(t + cl + j) % 64] = 1'b1;
    end
  endtask : rd

  // ****************
  // Scenarios
  // ****************
  initial begin
    for (int i = 0; i < 64; i++) begin
      eo[i] = 2'h0;
      ev[i] = 1'b0;
    end
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_MODE, 32'h0);
    chk(rd_val, 32'h0000000e);
    st(32'h00000009);
    apb(1'b0, 12'h00c, 32'h0);
    chk({err, rd_val[30:0]}, 32'h80000000);
    apb(1'b1, REG_STATUS, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test registers done");
    cmd(CMD_ACTIVE, 12'h955);
    cmd(CMD_ACTIVE, 12'h5aa);
    st(32'h00000012);
    cmd(CMD_PRECHARGE, 12'h800);
    st(32'h0000000a);
    cmd(CMD_ACTIVE, 12'h800);
    nop(3);
    cmd(CMD_PRECHARGE, 12'h400);
    st(32'h00000009);
    cmd(CMD_ACTIVE, 12'h000);
    $display("test banks done");
    wr(12'h000, 8, 16'h1000, 2'h0);
    wr(12'h005, 2, 16'h2000, 2'h0);
    wr(12'h002, 8, 16'h3000, 2'h1);
    nop(1);
    rd(12'h303);
    nop(12);
    mode(32'h0000002e);
    cmd(CMD_ACTIVE, 12'h000);
    rd(12'h006);
    ctl.step(NOP_CMD, 12'h000, 2'h2, 1'b0, 16'h0);
    rd(12'h001);
    nop(14);
    $display("test bursts done");
    mode(32'h0000000f);
    rd(12'h404);
    nop(12);
    st(32'h00000009);
    cmd(CMD_ACTIVE, 12'h000);
    mode(32'h00000006);
    wr(12'h404, 2, 16'h4000, 2'h0);
    nop(1);
    st(32'h00000089);
    cmd(CMD_ACTIVE, 12'h000);
    mode(32'h0000001e);
    wr(12'h4fe, 3, 16'h5000, 2'h0);
    cmd(CMD_BURST_STOP, 12'h000);
    st(32'h0000008a);
    mode(32'h00000006);
    rd(12'h0ff);
    nop(4);
    rd(12'h000);
    nop(6);
    $display("test auto precharge done");
    mode(32'h0000000e);
    wr(12'h010, 8, 16'h6000, 2'h0);
    mode(32'h0000004e);
    wr(12'h012, 4, 16'h7000, 2'h0);
    nop(1);
    rd(12'h010);
    nop(12);
    $display("test single write done");
    tally_and_finish();
  end
endmodule : sdram_burst_precharge_core_bench
